// File: design/lt_time_top.sv
// local time, daylight saving, telegram scheduling and reference clocks
`include "lt_map.svh"
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - UTC is satellite time minus the leap-second count from the navigation message.
// - local time is UTC plus a settable offset, 3600 s standard and 7200 s in DST.
// - DST start is a settable yearly instant, reset to 0.
// - DST end is a settable yearly instant, reset to 0, so DST is off until set.
// - identical start and end settings keep local time on the standard offset.
// - the timecode output follows local time or plain UTC by a setting.
// - two serial ports, the first of them the USB bridged port, both can send telegrams.
// - both ports stay inactive until sync unless set to start at once; reset clears that setting.
// - baud rate, format and telegram type are held per port.
// - a port sends every second, every minute or when asked with a question mark.
// - the timing output is the 0.56 MHz alias of a 19.44 MHz step at the 20 MHz clock; an 8 kHz frame clock is driven out.
// - every output frequency comes from the one master oscillator clock.
// - the oscillator correction value is kept in non-volatile memory.
module lt_time_top
  import lt_pkg::*;
#(
  parameter int TICKS_PER_SEC = 20000000
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // receiver time
  input wire logic gps_load,
  input wire logic [31:0] gps_seconds,
  input wire logic [7:0] leap_seconds,
  input wire logic rcv_synced,
  // timecode
  output logic [31:0] timecode_time,
  output logic pps_tick,
  // usb bridged serial port
  input wire logic usb_bridged_serial_port_rx_valid,
  input wire logic [7:0] usb_bridged_serial_port_rx_data,
  output logic usb_bridged_serial_port_active,
  output logic usb_bridged_serial_port_send,
  output logic [15:0] usb_bridged_serial_port_baud_div,
  output logic [3:0] usb_bridged_serial_port_format,
  output logic [3:0] usb_bridged_serial_port_tlg_type,
  // rs232 serial port
  input wire logic rs232_port_rx_valid,
  input wire logic [7:0] rs232_port_rx_data,
  output logic rs232_port_active,
  output logic rs232_port_send,
  output logic [15:0] rs232_port_baud_div,
  output logic [3:0] rs232_port_format,
  output logic [3:0] rs232_port_tlg_type,
  // oscillator correction memory
  input wire logic nvm_rd_valid,
  input wire logic [31:0] nvm_rd_data,
  output logic nvm_wr,
  output logic [31:0] nvm_wdata,
  output logic [31:0] osc_correction,
  // backplane reference clocks
  output logic sync_timing_clock_out,
  output logic frame_clock_out
);

  // ****************************************
  // declarations
  // ****************************************
  logic [31:0] ctrl;
  logic [31:0] offs_std;
  logic [31:0] offs_dst;
  logic [31:0] dst_start;
  logic [31:0] dst_end;
  logic [31:0] year_len;
  logic [31:0] port_cfg [2];
  logic [31:0] utc;
  logic [31:0] local_time;
  logic [31:0] presc;
  logic [31:0] sec_of_min;
  logic [31:0] next_utc;
  logic sync_ff1;
  logic sync_ff2;
  logic dst_active;
  logic next_dst;
  logic dst_enabled;
  logic sec_tick;
  logic min_tick;
  logic ports_on;
  logic [1:0] send_vec;
  logic [1:0] rx_valid_vec;
  logic [7:0] rx_data_vec [2];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic lt_mode_t cfg_mode(input logic [31:0] cfg);
    cfg_mode = lt_mode_t'(cfg[`LT_CFG_MODE_HI:`LT_CFG_MODE_LO]);
  endfunction

  // ****************************************
  // receiver sync pin
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_ff1 <= 1'b0;
      sync_ff2 <= 1'b0;
    end
    else if (ce)
    begin
      sync_ff1 <= rcv_synced;
      sync_ff2 <= sync_ff1;
    end
  end

  // ****************************************
  // second prescaler, clk is the disciplined oscillator
  // ****************************************
  assign sec_tick = (presc == 32'(TICKS_PER_SEC - 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      presc <= 32'h00000000;
    else if (ce)
    begin
      if (gps_load || sec_tick)
        presc <= 32'h00000000;
      else
        presc <= presc + 32'h00000001;
    end
  end

  // ****************************************
  // utc and local time
  // ****************************************
  assign next_utc = utc + 32'h00000001;
  assign min_tick = sec_tick && (sec_of_min == (`LT_SEC_PER_MIN - 32'h00000001));
  assign dst_enabled = (dst_start != dst_end);
  assign next_dst = dst_enabled && (next_utc >= dst_start) && (next_utc < dst_end);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      utc <= 32'h00000000;
      sec_of_min <= 32'h00000000;
    end
    else if (ce)
    begin
      if (gps_load)
      begin
        utc <= gps_seconds - {24'h000000, leap_seconds};
        sec_of_min <= (gps_seconds - {24'h000000, leap_seconds}) % `LT_SEC_PER_MIN;
      end
      else if (sec_tick)
      begin
        utc <= next_utc;
        sec_of_min <= min_tick ? 32'h00000000 : sec_of_min + 32'h00000001;
      end
    end
  end

  // dst flag and offset move together on the tick so no telegram sees a mix
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dst_active <= 1'b0;
      local_time <= 32'h00000000;
      pps_tick <= 1'b0;
    end
    else if (ce)
    begin
      pps_tick <= sec_tick;
      if (sec_tick)
      begin
        dst_active <= next_dst;
        local_time <= next_utc + (next_dst ? offs_dst : offs_std);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      timecode_time <= 32'h00000000;
    else if (ce && sec_tick)
    begin
      if (ctrl[`LT_CTRL_TC_UTC])
        timecode_time <= next_utc;
      else
        timecode_time <= next_utc + (next_dst ? offs_dst : offs_std);
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= 32'h00000000;
      offs_std <= `LT_RST_OFFS_STD;
      offs_dst <= `LT_RST_OFFS_DST;
      year_len <= `LT_RST_YEAR_LEN;
    end
    else if (ce && reg_wr)
    begin
      if (hit(reg_addr, `LT_A_CTRL))
        ctrl <= reg_wdata;
      if (hit(reg_addr, `LT_A_OFFS_STD))
        offs_std <= reg_wdata;
      if (hit(reg_addr, `LT_A_OFFS_DST))
        offs_dst <= reg_wdata;
      if (hit(reg_addr, `LT_A_YEAR_LEN))
        year_len <= reg_wdata;
    end
  end

  // once the end has passed both instants roll on by one year
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dst_start <= 32'h00000000;
      dst_end <= 32'h00000000;
    end
    else if (ce)
    begin
      if (reg_wr && hit(reg_addr, `LT_A_DST_START))
        dst_start <= reg_wdata;
      else if (sec_tick && dst_enabled && next_utc >= dst_end)
        dst_start <= dst_start + year_len;
      if (reg_wr && hit(reg_addr, `LT_A_DST_END))
        dst_end <= reg_wdata;
      else if (sec_tick && dst_enabled && next_utc >= dst_end)
        dst_end <= dst_end + year_len;
    end
  end

  // ****************************************
  // oscillator correction, mirrored to non-volatile memory
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_correction <= 32'h00000000;
      nvm_wr <= 1'b0;
      nvm_wdata <= 32'h00000000;
    end
    else if (ce)
    begin
      nvm_wr <= reg_wr && hit(reg_addr, `LT_A_CORR);
      if (reg_wr && hit(reg_addr, `LT_A_CORR))
      begin
        osc_correction <= reg_wdata;
        nvm_wdata <= reg_wdata;
      end
      else if (nvm_rd_valid)
        osc_correction <= nvm_rd_data;
    end
  end

  // ****************************************
  // serial ports
  // ****************************************
  assign rx_valid_vec = {rs232_port_rx_valid, usb_bridged_serial_port_rx_valid};
  assign rx_data_vec[0] = usb_bridged_serial_port_rx_data;
  assign rx_data_vec[1] = rs232_port_rx_data;
  assign ports_on = sync_ff2 || ctrl[`LT_CTRL_IMMEDIATE];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_port
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          port_cfg[gi] <= `LT_RST_PORT_CFG;
        else if (ce && reg_wr && hit(reg_addr, `LT_A_PORT0 + 8'(gi * 4)))
          port_cfg[gi] <= reg_wdata;
      end

      lt_tlg_sched u_sched (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .active(ports_on),
        .mode(cfg_mode(port_cfg[gi])),
        .sec_tick(sec_tick),
        .min_tick(min_tick),
        .rx_valid(rx_valid_vec[gi]),
        .rx_data(rx_data_vec[gi]),
        .send(send_vec[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      usb_bridged_serial_port_active <= 1'b0;
      rs232_port_active <= 1'b0;
    end
    else if (ce)
    begin
      usb_bridged_serial_port_active <= ports_on;
      rs232_port_active <= ports_on;
    end
  end

  assign usb_bridged_serial_port_send = send_vec[0];
  assign rs232_port_send = send_vec[1];
  assign usb_bridged_serial_port_baud_div = port_cfg[0][`LT_CFG_BAUD_HI:`LT_CFG_BAUD_LO];
  assign usb_bridged_serial_port_format = port_cfg[0][`LT_CFG_FMT_HI:`LT_CFG_FMT_LO];
  assign usb_bridged_serial_port_tlg_type = port_cfg[0][`LT_CFG_TYPE_HI:`LT_CFG_TYPE_LO];
  assign rs232_port_baud_div = port_cfg[1][`LT_CFG_BAUD_HI:`LT_CFG_BAUD_LO];
  assign rs232_port_format = port_cfg[1][`LT_CFG_FMT_HI:`LT_CFG_FMT_LO];
  assign rs232_port_tlg_type = port_cfg[1][`LT_CFG_TYPE_HI:`LT_CFG_TYPE_LO];

  // ****************************************
  // reference clocks
  // ****************************************
  // above half the clock rate the timing output is an alias, a pll must clean it
  lt_nco u_timing (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .inc(`LT_INC_TIMING),
    .clk_out(sync_timing_clock_out)
  );

  lt_nco u_frame (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .inc(`LT_INC_FRAME),
    .clk_out(frame_clock_out)
  );

  // ****************************************
  // register read
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h00000000;
    else if (ce)
    begin
      reg_rdata <= 32'h00000000;
      if (reg_rd)
      begin
        case (reg_addr)
          `LT_A_CTRL: reg_rdata <= ctrl;
          `LT_A_STATUS: reg_rdata <= {29'h00000000, ports_on, dst_active, sync_ff2};
          `LT_A_OFFS_STD: reg_rdata <= offs_std;
          `LT_A_OFFS_DST: reg_rdata <= offs_dst;
          `LT_A_DST_START: reg_rdata <= dst_start;
          `LT_A_DST_END: reg_rdata <= dst_end;
          `LT_A_YEAR_LEN: reg_rdata <= year_len;
          `LT_A_CORR: reg_rdata <= osc_correction;
          `LT_A_PORT0: reg_rdata <= port_cfg[0];
          `LT_A_PORT1: reg_rdata <= port_cfg[1];
          `LT_A_UTC: reg_rdata <= utc;
          `LT_A_LOCAL: reg_rdata <= local_time;
          `LT_A_LEAP: reg_rdata <= {24'h000000, leap_seconds};
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// File: design/lt_map.svh
// register offsets, field positions and reset values of the local time block
`ifndef LT_MAP_SVH
`define LT_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define LT_A_CTRL 8'h00
`define LT_A_STATUS 8'h04
`define LT_A_OFFS_STD 8'h08
`define LT_A_OFFS_DST 8'h0c
`define LT_A_DST_START 8'h10
`define LT_A_DST_END 8'h14
`define LT_A_YEAR_LEN 8'h18
`define LT_A_CORR 8'h1c
`define LT_A_PORT0 8'h20
`define LT_A_PORT1 8'h24
`define LT_A_UTC 8'h28
`define LT_A_LOCAL 8'h2c
`define LT_A_LEAP 8'h30

// ****************************************
// field positions
// ****************************************
`define LT_CTRL_IMMEDIATE 0
`define LT_CTRL_TC_UTC 1
`define LT_ST_SYNCED 0
`define LT_ST_DST 1
`define LT_ST_ACTIVE 2
`define LT_CFG_BAUD_HI 15
`define LT_CFG_BAUD_LO 0
`define LT_CFG_FMT_HI 19
`define LT_CFG_FMT_LO 16
`define LT_CFG_TYPE_HI 23
`define LT_CFG_TYPE_LO 20
`define LT_CFG_MODE_HI 25
`define LT_CFG_MODE_LO 24

// ****************************************
// reset values and constants
// ****************************************
`define LT_RST_OFFS_STD 32'h00000e10
`define LT_RST_OFFS_DST 32'h00001c20
`define LT_RST_YEAR_LEN 32'h01e13380
`define LT_RST_PORT_CFG 32'h01000000
`define LT_SEC_PER_MIN 32'h0000003c
`define LT_ASK_CHAR 8'h3f
// accumulator steps: f_out / 20 MHz * 2^32
`define LT_INC_TIMING 32'hf8d4fdf3
`define LT_INC_FRAME 32'h001a36e3

`endif

// File: design/lt_pkg.sv
// types shared by the local time block
package lt_pkg;

  // telegram scheduling per serial port
  typedef enum logic [1:0] {
    LT_MODE_OFF = 2'h0,
    LT_MODE_SEC = 2'h1,
    LT_MODE_MIN = 2'h2,
    LT_MODE_REQ = 2'h3
  } lt_mode_t;

endpackage

// File: design/lt_nco.sv
// phase accumulator clock generator running off the master oscillator
`timescale 1ns/1ps
`default_nettype none
module lt_nco
  import lt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // step and output
  input wire logic [31:0] inc,
  output logic clk_out
);

  logic [31:0] acc;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      acc <= 32'h00000000;
    else if (ce)
      acc <= acc + inc;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      clk_out <= 1'b0;
    else if (ce)
      clk_out <= acc[31];
  end

endmodule
`default_nettype wire

// File: design/lt_tlg_sched.sv
// telegram send scheduler of one serial port
`include "lt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module lt_tlg_sched
  import lt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // configuration
  input wire logic active,
  input wire lt_mode_t mode,
  // time events
  input wire logic sec_tick,
  input wire logic min_tick,
  // received characters
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // send request
  output logic send
);

  logic ask;

  assign ask = rx_valid && (rx_data == `LT_ASK_CHAR);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      send <= 1'b0;
    else if (ce)
    begin
      case (mode)
        LT_MODE_SEC: send <= active && sec_tick;
        LT_MODE_MIN: send <= active && min_tick;
        LT_MODE_REQ: send <= active && ask;
        default: send <= 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: sim/lt_time_assertions.sv
// concurrent checks on the ports of the local time block
`include "lt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module lt_time_chk #(
  parameter int TICKS_PER_SEC = 20
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // receiver time and timecode
  input wire logic gps_load,
  input wire logic rcv_synced,
  input wire logic [31:0] timecode_time,
  input wire logic pps_tick,
  // serial ports
  input wire logic usb_bridged_serial_port_rx_valid,
  input wire logic usb_bridged_serial_port_active,
  input wire logic usb_bridged_serial_port_send,
  input wire logic [15:0] usb_bridged_serial_port_baud_div,
  input wire logic [3:0] usb_bridged_serial_port_format,
  input wire logic [3:0] usb_bridged_serial_port_tlg_type,
  input wire logic rs232_port_active,
  input wire logic rs232_port_send,
  // correction memory
  input wire logic nvm_rd_valid,
  input wire logic [31:0] nvm_rd_data,
  input wire logic nvm_wr,
  input wire logic [31:0] nvm_wdata,
  input wire logic [31:0] osc_correction
);
  // ****
  // second gap counter; a time load restarts the second
  // ****
  logic [31:0] gap;
  logic gap_ok;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gap <= 32'h0;
      gap_ok <= 1'b0;
    end
    else
    begin
      gap <= pps_tick ? 32'h0 : gap + 32'h1;
      gap_ok <= (pps_tick | gap_ok) & ~gps_load;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_nvm_wr;
    reg_wr && reg_addr == `LT_A_CORR |=> nvm_wr && nvm_wdata == $past(reg_wdata)
      && osc_correction == $past(reg_wdata);
  endproperty
  a_nvm_wr: assert property (p_nvm_wr) else $error("correction not stored");
  property p_nvm_ld;
    nvm_rd_valid && !(reg_wr && reg_addr == `LT_A_CORR) |=> osc_correction == $past(nvm_rd_data);
  endproperty
  a_nvm_ld: assert property (p_nvm_ld) else $error("stored correction not loaded");
  property p_usb_gate;
    usb_bridged_serial_port_send |-> usb_bridged_serial_port_active
      || $past(usb_bridged_serial_port_active);
  endproperty
  a_usb_gate: assert property (p_usb_gate) else $error("inactive usb port sent");
  property p_rs_gate;
    rs232_port_send |-> rs232_port_active || $past(rs232_port_active);
  endproperty
  a_rs_gate: assert property (p_rs_gate) else $error("inactive rs232 port sent");
  property p_sync_act;
    rcv_synced [*4] |-> usb_bridged_serial_port_active && rs232_port_active;
  endproperty
  a_sync_act: assert property (p_sync_act) else $error("ports idle after sync");
  property p_tc_hold;
    $changed(timecode_time) |-> pps_tick;
  endproperty
  a_tc_hold: assert property (p_tc_hold) else $error("timecode moved off second");
  property p_pps_gap;
    pps_tick && gap_ok |-> gap == TICKS_PER_SEC - 1;
  endproperty
  a_pps_gap: assert property (p_pps_gap) else $error("second length wrong");
  property p_cfg_usb;
    reg_wr && reg_addr == `LT_A_PORT0 |=> {usb_bridged_serial_port_tlg_type,
      usb_bridged_serial_port_format, usb_bridged_serial_port_baud_div} == $past(reg_wdata[23:0]);
  endproperty
  a_cfg_usb: assert property (p_cfg_usb) else $error("usb port settings wrong");
  property p_usb_cause;
    usb_bridged_serial_port_send |-> pps_tick || $past(usb_bridged_serial_port_rx_valid);
  endproperty
  a_usb_cause: assert property (p_usb_cause) else $error("usb send without cause");

  c_nvm: cover property (nvm_wr);
  c_ask: cover property (usb_bridged_serial_port_send && $past(usb_bridged_serial_port_rx_valid));
  c_sec: cover property (rs232_port_send && pps_tick);
endmodule

bind lt_time_top lt_time_chk #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_chk (.*);
`default_nettype wire

// File: sim/lt_host_model.sv
// terminal model on one serial port: types characters on command
`timescale 1ns/1ps
`default_nettype none
module lt_host_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // commands from the bench
  input wire logic ask,
  input wire logic [7:0] ask_char,
  // received character toward the block
  output logic rx_valid,
  output logic [7:0] rx_data
);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end
    else
    begin
      // data toggle between characters so stale values never look valid
      rx_valid <= ask;
      rx_data <= ask ? ask_char : ~rx_data;
    end
  end
endmodule
`default_nettype wire

// File: sim/lt_time_top_tb.sv
// self-checking bench of the local time block
`include "lt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module lt_time_top_tb;
  import lt_pkg::*;
  localparam int TK = 20;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, leap_seconds = 8'h00, ask_char = 8'h00;
  logic [31:0] reg_wdata = 32'h0, gps_seconds = 32'h0, nvm_rd_data = 32'h0;
  logic gps_load = 1'b0, rcv_synced = 1'b0, nvm_rd_valid = 1'b0;
  logic [1:0] ask = 2'b00;
  logic [31:0] reg_rdata, timecode_time, nvm_wdata, osc_correction;
  logic pps_tick, nvm_wr, sync_timing_clock_out, frame_clock_out;
  logic usb_bridged_serial_port_rx_valid, usb_bridged_serial_port_active;
  logic usb_bridged_serial_port_send, rs232_port_rx_valid, rs232_port_active, rs232_port_send;
  logic [7:0] usb_bridged_serial_port_rx_data, rs232_port_rx_data;
  logic [15:0] usb_bridged_serial_port_baud_div, rs232_port_baud_div;
  logic [3:0] usb_bridged_serial_port_format, usb_bridged_serial_port_tlg_type;
  logic [3:0] rs232_port_format, rs232_port_tlg_type;
  // ****
  // reference model state
  // ****
  logic [31:0] utc, s = 32'h0, e = 32'h0, ost = `LT_RST_OFFS_STD, v;
  logic trk = 1'b0, on = 1'b0, tcu = 1'b0, dst, pt = 1'b0, pf = 1'b0;
  logic [1:0] am = 2'b00, pv = 2'b00;
  logic [7:0] pd0, pd1;
  lt_mode_t md [2] = '{LT_MODE_SEC, LT_MODE_SEC};
  int err_total = 0, n_compared = 0, cyc = 0, nt = 0, nf = 0, et, ef;

  lt_time_top #(.TICKS_PER_SEC(TK)) dut (.*);
  lt_host_model u_h0 (.clk(clk), .rst_n(rst_n), .ask(ask[0]), .ask_char(ask_char),
    .rx_valid(usb_bridged_serial_port_rx_valid), .rx_data(usb_bridged_serial_port_rx_data));
  lt_host_model u_h1 (.clk(clk), .rst_n(rst_n), .ask(ask[1]), .ask_char(ask_char),
    .rx_valid(rs232_port_rx_valid), .rx_data(rs232_port_rx_data));

  always #25 clk = ~clk;

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] d;
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk(d, x);
  endtask
  // checking pauses so the model never races a setting change
  task automatic set(input logic [7:0] a, input logic [31:0] d);
    on = 1'b0;
    wr(a, d);
    @(negedge clk);
    @(posedge clk);
  endtask
  task automatic run(input int n);
    on = 1'b1;
    repeat (n * TK)
    begin
      @(posedge clk);
      ask <= ($urandom % 5 == 0) ? 2'($urandom) : 2'b00;
      ask_char <= ($urandom % 2) ? `LT_ASK_CHAR : 8'($urandom);
    end
    @(posedge clk);
    ask <= 2'b00;
  endtask
  function automatic logic es(input int p, input logic rv, input logic [7:0] rd);
    return am[p] && (md[p] == LT_MODE_SEC && pps_tick
      || md[p] == LT_MODE_MIN && pps_tick && utc % 60 == 0
      || md[p] == LT_MODE_REQ && rv && rd == `LT_ASK_CHAR);
  endfunction

  // ****
  // per-cycle model comparison
  // ****
  always @(negedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      finish_test();
    end
    if (trk && pps_tick)
    begin
      utc = utc + 32'h1;
      dst = s != e && s <= utc && utc < e;
      if (on)
        chk(timecode_time, tcu ? utc : utc + (dst ? `LT_RST_OFFS_DST : ost));
      if (s != e && utc == e)
      begin
        s = s + `LT_RST_YEAR_LEN;
        e = e + `LT_RST_YEAR_LEN;
      end
    end
    if (on)
    begin
      chk(32'(usb_bridged_serial_port_send), 32'(es(0, pv[0], pd0)));
      chk(32'(rs232_port_send), 32'(es(1, pv[1], pd1)));
    end
    nt += int'(sync_timing_clock_out && !pt);
    nf += int'(frame_clock_out && !pf);
    pt = sync_timing_clock_out;
    pf = frame_clock_out;
    pv = {rs232_port_rx_valid, usb_bridged_serial_port_rx_valid};
    pd0 = usb_bridged_serial_port_rx_data;
    pd1 = rs232_port_rx_data;
  end

  initial
  begin
    void'($urandom(32'hfd9bad5b));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rc(`LT_A_OFFS_STD, `LT_RST_OFFS_STD);
    rc(`LT_A_OFFS_DST, `LT_RST_OFFS_DST);
    rc(`LT_A_PORT0, `LT_RST_PORT_CFG);
    rc(8'h40, 32'h0);
    v = $urandom % 32'h40000000;
    @(posedge clk);
    gps_seconds <= v;
    leap_seconds <= 8'($urandom % 40);
    gps_load <= 1'b1;
    @(posedge clk);
    gps_load <= 1'b0;
    utc = v - 32'(leap_seconds);
    trk = 1'b1;
    rc(`LT_A_LEAP, 32'(leap_seconds));
    run(3);
    // the model steps utc on the negedge before, so no race with it here
    @(posedge clk iff pps_tick);
    rc(`LT_A_UTC, utc);
    on = 1'b0;
    rcv_synced <= 1'b1;
    repeat (5) @(posedge clk);
    am = 2'b11;
    rc(`LT_A_STATUS, 32'h5);
    for (int m = 0; m < 4; m++)
    begin
      v = $urandom;
      set(`LT_A_PORT0, {6'h0, 2'(m), v[23:0]});
      set(`LT_A_PORT1, {6'h0, 2'(3 - m), ~v[23:0]});
      md = '{lt_mode_t'(m), lt_mode_t'(3 - m)};
      chk({8'h0, usb_bridged_serial_port_tlg_type, usb_bridged_serial_port_format,
        usb_bridged_serial_port_baud_div}, {8'h0, v[23:0]});
      chk({8'h0, rs232_port_tlg_type, rs232_port_format, rs232_port_baud_div},
        {8'h0, ~v[23:0]});
      run(65);
    end
    v = utc;
    // end first: a lone start against end 0 would trigger the yearly roll
    set(`LT_A_DST_END, v + 32'h6);
    set(`LT_A_DST_START, v + 32'h3);
    s = v + 32'h3;
    e = v + 32'h6;
    run(9);
    v = utc;
    set(`LT_A_DST_START, v + 32'h2);
    set(`LT_A_DST_END, v + 32'h2);
    s = v + 32'h2;
    e = s;
    run(4);
    set(`LT_A_OFFS_STD, 32'h1518);
    ost = 32'h1518;
    run(3);
    set(`LT_A_CTRL, 32'h3);
    tcu = 1'b1;
    run(3);
    v = $urandom;
    wr(`LT_A_CORR, v);
    @(negedge clk);
    chk(nvm_wdata, v);
    @(posedge clk);
    nvm_rd_valid <= 1'b1;
    nvm_rd_data <= ~v;
    @(posedge clk);
    nvm_rd_valid <= 1'b0;
    @(negedge clk);
    chk(osc_correction, ~v);
    nt = 0;
    nf = 0;
    repeat (25000) @(posedge clk);
    et = int'((64'd25000 * (64'h100000000 - 64'(`LT_INC_TIMING))) >> 32);
    ef = int'((64'd25000 * 64'(`LT_INC_FRAME)) >> 32);
    chk(32'(nt >= et - 1 && nt <= et + 1), 32'h1);
    chk(32'(nf >= ef - 1 && nf <= ef + 1), 32'h1);
    // second reset: ports must fall back to waiting for sync
    on = 1'b0;
    trk = 1'b0;
    rst_n <= 1'b0;
    rcv_synced <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(negedge clk);
    chk(32'({usb_bridged_serial_port_active, rs232_port_active}), 32'h0);
    wr(`LT_A_CTRL, 32'h1);
    repeat (2) @(negedge clk);
    chk(32'({usb_bridged_serial_port_active, rs232_port_active}), 32'h3);
    finish_test();
  end
endmodule
`default_nettype wire
